/* cbm_pkg.sv */
// Package for the comparator blanking mask gate: register map, field positions, bus carrier.
// Assumes a 16-bit control register reached over Avalon-MM with 32-bit data.
package cbm_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STAT_OFFSET = 4'h4;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_WR_MASK = 16'hBFFF;

  localparam int unsigned POS_BLANK_POL = 15;
  localparam int unsigned POS_OR_C_T = 13;
  localparam int unsigned POS_OR_C_N = 12;
  localparam int unsigned POS_OR_B_T = 11;
  localparam int unsigned POS_OR_B_N = 10;
  localparam int unsigned POS_OR_A_T = 9;
  localparam int unsigned POS_OR_A_N = 8;
  localparam int unsigned POS_AND_N_OR = 7;
  localparam int unsigned POS_AND_T_OR = 6;
  localparam int unsigned POS_AND_C_T = 5;
  localparam int unsigned POS_AND_C_N = 4;
  localparam int unsigned POS_AND_B_T = 3;
  localparam int unsigned POS_AND_B_N = 2;
  localparam int unsigned POS_AND_A_T = 1;
  localparam int unsigned POS_AND_A_N = 0;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } cbm_avl_req_t;

endpackage

/* cbm_gate.sv */
// Combinational mask gate network: three mask sources into an AND gate and an OR gate.
// Assumes the control word is stable register state; the caller registers the result.
`timescale 1ns/1ns
module cbm_gate
(
  input wire logic [15:0] ctrl_i,
  input wire logic [2:0] src_i,
  output logic and_gate_result_o,
  output logic blank_o
);
  import cbm_pkg::*;

  wire logic [2:0] or_true_en = {ctrl_i[POS_OR_C_T], ctrl_i[POS_OR_B_T], ctrl_i[POS_OR_A_T]};
  wire logic [2:0] or_inv_en = {ctrl_i[POS_OR_C_N], ctrl_i[POS_OR_B_N], ctrl_i[POS_OR_A_N]};
  wire logic [2:0] and_true_en = {ctrl_i[POS_AND_C_T], ctrl_i[POS_AND_B_T], ctrl_i[POS_AND_A_T]};
  wire logic [2:0] and_inv_en = {ctrl_i[POS_AND_C_N], ctrl_i[POS_AND_B_N], ctrl_i[POS_AND_A_N]};
  wire logic [5:0] or_terms = {or_true_en & src_i, or_inv_en & ~src_i};
  wire logic [5:0] and_terms = {and_true_en & src_i, and_inv_en & ~src_i};
  // An AND gate with no input enabled gives 0, so an empty gate blanks only through ctrl_i[POS_AND_N_OR]
  wire logic and_any = |{and_true_en, and_inv_en};
  wire logic and_res = and_any & (&(and_terms | ~{and_true_en, and_inv_en}));

  assign and_gate_result_o = and_res;
  assign blank_o = (|or_terms) | (ctrl_i[POS_AND_T_OR] & and_res)
    | (ctrl_i[POS_AND_N_OR] & ~and_res);
endmodule

/* cbm_mask_gate.sv */
// Top of the comparator blanking mask gate: Avalon-MM slave plus registered blanking path.
// Assumes mask sources and comparator level are synchronous to ref_clk_i.
`timescale 1ns/1ns
module cbm_mask_gate
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [cbm_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic mask_source_a_i,
  input wire logic mask_source_b_i,
  input wire logic mask_source_c_i,
  input wire logic comp_i,
  output logic comp_o,
  output logic blank_o
);
  import cbm_pkg::*;

  cbm_avl_req_t req;
  logic [15:0] ctrl_q;
  logic [15:0] ctrl_d;
  logic ack_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic blank_q;
  logic comp_q;
  logic and_res;
  logic blank_c;

  assign req = '{read: avs_read_i, write: avs_write_i, address: avs_address_i,
                 byteenable: avs_byteenable_i, writedata: avs_writedata_i};

  // One wait cycle per access: the access completes on the edge after ack_q rises
  wire logic access = (req.read | req.write) & ~ack_q;
  wire logic hit_ctrl = (req.address == CTRL_OFFSET);
  wire logic hit_stat = (req.address == STAT_OFFSET);
  // Writes wait for the completing edge, so a held request lands exactly once
  wire logic do_write = ack_q & req.write & hit_ctrl;
  wire logic [15:0] be_mask = {{8{req.byteenable[1]}}, {8{req.byteenable[0]}}};
  wire logic [15:0] wr_mask = be_mask & CTRL_WR_MASK;
  assign ctrl_d = do_write ? ((ctrl_q & ~wr_mask) | (req.writedata[15:0] & wr_mask)) : ctrl_q;

  // Status word: live OR result, both registered outputs and the AND result
  wire logic [3:0] stat_bits = {and_res, blank_q, comp_q, blank_c};

  // Unmapped addresses read zero and swallow writes
  assign rdata_d = hit_ctrl ? {16'h0000, ctrl_q & CTRL_WR_MASK}
                 : hit_stat ? {28'h0000000, stat_bits}
                 : 32'h00000000;

  cbm_gate u_gate
  (
    .ctrl_i(ctrl_q),
    .src_i({mask_source_c_i, mask_source_b_i, mask_source_a_i}),
    .and_gate_result_o(and_res),
    .blank_o(blank_c)
  );

  // Asserted level is 0 when polarity is set, else 1; blanked output sits at the idle level
  wire logic asserted = ctrl_q[POS_BLANK_POL] ? ~comp_i : comp_i;
  wire logic comp_next = (blank_c & asserted) ? ctrl_q[POS_BLANK_POL] : comp_i;

  // Control register: a write lands only on the edge where waitrequest is sampled low
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= CTRL_RESET;
    end
    else
    begin
      ctrl_q <= ctrl_d;
    end
  end

  // Handshake: wait_q is a flop of its own so the bus sees a register, not an inverter
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      wait_q <= 1'b1;
    end
    else
    begin
      ack_q <= access;
      wait_q <= ~access;
    end
  end

  // Read data is captured as the request is taken and holds until the next access
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rdata_q <= 32'h00000000;
    end
    else if (access)
    begin
      rdata_q <= rdata_d;
    end
  end

  // Blanking path: one cycle from mask sources and comparator level to the pins
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      blank_q <= 1'b0;
      comp_q <= 1'b0;
    end
    else
    begin
      blank_q <= blank_c;
      comp_q <= comp_next;
    end
  end

  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o = rdata_q;
  assign blank_o = blank_q;
  assign comp_o = comp_q;

  a_pol_low_blank: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ctrl_q[POS_BLANK_POL] && blank_c && !comp_i) |=> comp_o)
    else $error("asserted-low level passed while blanking");
  a_pol_high_blank: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!ctrl_q[POS_BLANK_POL] && blank_c && comp_i) |=> !comp_o)
    else $error("asserted-high level passed while blanking");
  a_src_c_or: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ((ctrl_q[POS_OR_C_T] && mask_source_c_i) || (ctrl_q[POS_OR_C_N] && !mask_source_c_i)) |=> blank_o)
    else $error("source C did not blank");
  a_src_b_true: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ctrl_q[POS_OR_B_T] && mask_source_b_i) |=> blank_o)
    else $error("true source B did not blank");
  a_src_b_inv: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ctrl_q[POS_OR_B_N] && !mask_source_b_i) |=> blank_o)
    else $error("inverted source B did not blank");
  a_src_a_or: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ((ctrl_q[POS_OR_A_T] && mask_source_a_i) || (ctrl_q[POS_OR_A_N] && !mask_source_a_i)) |=> blank_o)
    else $error("source A did not blank");
  a_unused_bit_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!avs_waitrequest_o && hit_ctrl && avs_read_i) |-> !avs_readdata_o[14])
    else $error("bit 14 read as one");
  a_and_to_or: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ((ctrl_q[POS_AND_T_OR] && and_res) || (ctrl_q[POS_AND_N_OR] && !and_res)) |=> blank_o)
    else $error("AND result did not blank");
  a_idle_no_blank: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ctrl_q[13:0] == 14'h0000) |=> !blank_o)
    else $error("blank without any enable");

  // Bus handshake: one wait cycle, answer held, nothing lands while waiting
  a_wait_one_cycle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ((avs_read_i || avs_write_i) && avs_waitrequest_o) |=> !avs_waitrequest_o)
    else $error("request not answered after one wait cycle");
  a_wait_low_once: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!avs_waitrequest_o) |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  a_no_write_waiting: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    avs_waitrequest_o |=> $stable(ctrl_q))
    else $error("control changed while waitrequest was high");
  a_rdata_held: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !access |=> $stable(avs_readdata_o))
    else $error("read data changed without an access");
  a_unmapped_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (access && avs_read_i && !hit_ctrl && !hit_stat) |=> (avs_readdata_o == 32'h00000000))
    else $error("unmapped read returned nonzero data");
  a_stat_upper_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (access && avs_read_i && hit_stat) |=> (avs_readdata_o[31:4] == 28'h0000000))
    else $error("status upper bits nonzero");
  a_write_lands: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (avs_write_i && !avs_waitrequest_o && hit_ctrl && (avs_byteenable_i[1:0] == 2'h3))
    |=> (ctrl_q == ($past(avs_writedata_i[15:0]) & CTRL_WR_MASK)))
    else $error("control write did not land as masked");
  a_spare_bit_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !ctrl_q[14])
    else $error("spare control bit was set");

  // Levels that are not the asserted one always pass unchanged
  a_pol_low_pass: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ctrl_q[POS_BLANK_POL] && comp_i) |=> comp_o)
    else $error("idle-high level did not pass");
  a_pol_high_pass: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!ctrl_q[POS_BLANK_POL] && !comp_i) |=> !comp_o)
    else $error("idle-low level did not pass");
  a_unblanked_pass: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !blank_c |=> (comp_o == $past(comp_i)))
    else $error("comparator level altered without blanking");

  // A single OR enable must not blank when its source form is low
  a_src_c_true_only: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ((ctrl_q[13:6] == 8'h80) && !mask_source_c_i) |=> !blank_o)
    else $error("low source C blanked through true input");
  a_src_c_inv_only: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ((ctrl_q[13:6] == 8'h40) && mask_source_c_i) |=> !blank_o)
    else $error("high source C blanked through inverted input");
  a_src_b_true_only: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ((ctrl_q[13:6] == 8'h20) && !mask_source_b_i) |=> !blank_o)
    else $error("low source B blanked through true input");
  a_src_b_inv_only: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ((ctrl_q[13:6] == 8'h10) && mask_source_b_i) |=> !blank_o)
    else $error("high source B blanked through inverted input");
  a_src_a_true_only: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ((ctrl_q[13:6] == 8'h08) && !mask_source_a_i) |=> !blank_o)
    else $error("low source A blanked through true input");
  a_src_a_inv_only: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ((ctrl_q[13:6] == 8'h04) && mask_source_a_i) |=> !blank_o)
    else $error("high source A blanked through inverted input");

  // AND gate: empty gives zero, all enabled true inputs high gives one
  a_and_empty_low: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ctrl_q[5:0] == 6'h00) |-> !and_res)
    else $error("AND gate with no inputs gave one");
  a_and_true_all: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ((ctrl_q[5:0] == 6'h2A) && mask_source_a_i && mask_source_b_i && mask_source_c_i) |-> and_res)
    else $error("AND gate missed all-high true inputs");
endmodule

/* cbm_src_model.sv */
// Far-side model: mask sources and comparator level feeding the blanking gate.
// Assumes the bench picks levels {comp, c, b, a}; they change just after a rising edge.
`timescale 1ns/1ns
module cbm_src_model (
  input wire logic clk_i,
  input wire logic [3:0] lvl_i,
  output logic [3:0] lvl_o
);
  always_ff @(posedge clk_i)
  begin
    lvl_o <= lvl_i;
  end
endmodule

/* cbm_mask_gate_tb.sv */
// Self-checking bench for the blanking mask gate: register access and gate sweep.
// Assumes the one-wait-cycle Avalon slave and one-cycle output latency of the top.
`timescale 1ns/1ns
module cbm_mask_gate_tb;
  import cbm_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic rd_q = 1'b0;
  logic wr_q = 1'b0;
  logic [3:0] adr_q = 4'h0;
  logic [3:0] be_q = 4'h0;
  logic [3:0] lvl = 4'h0;
  logic [3:0] src;
  logic [31:0] wd_q = 32'h0;
  logic [31:0] rdata;
  logic [31:0] q;
  logic wait_o;
  logic comp_o;
  logic blank_o;
  int err_count = 0;
  int n_compared = 0;
  always #25 ref_clk_i = ~ref_clk_i;
  cbm_src_model sm (.clk_i(ref_clk_i), .lvl_i(lvl), .lvl_o(src));
  cbm_mask_gate dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .avs_read_i(rd_q), .avs_write_i(wr_q),
    .avs_address_i(adr_q), .avs_byteenable_i(be_q), .avs_writedata_i(wd_q), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_o), .mask_source_a_i(src[0]), .mask_source_b_i(src[1]),
    .mask_source_c_i(src[2]), .comp_i(src[3]), .comp_o(comp_o), .blank_o(blank_o));
  task close_out;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Holds the request until waitrequest is sampled low, then idles a cycle
  task bus(input logic w, input logic [3:0] a, input logic [3:0] b, input logic [31:0] d);
    int i;
    i = 0;
    rd_q <= !w;
    wr_q <= w;
    adr_q <= a;
    be_q <= b;
    wd_q <= d;
    do
    begin
      @(posedge ref_clk_i);
      i++;
    end
    while (wait_o !== 1'b0 && i < 20);
    q = rdata;
    rd_q <= 1'b0;
    wr_q <= 1'b0;
    if (i >= 20)
    begin
      err_count++;
      close_out();
    end
    @(posedge ref_clk_i);
  endtask
  function automatic logic exp_or(input logic [15:0] w, input logic a, input logic b, input logic c);
    logic [5:0] t;
    logic an;
    t = {c, ~c, b, ~b, a, ~a};
    an = (|w[5:0]) && (&(t | ~w[5:0]));
    return (|(t & w[13:8])) | (w[6] & an) | (w[7] & ~an);
  endfunction
  task reg_checks;
    bus(1'b0, CTRL_OFFSET, 4'hF, 32'h0);
    chk("ctrl reset", {16'h0000, CTRL_RESET}, q);
    bus(1'b1, CTRL_OFFSET, 4'hF, 32'hFFFFFFFF);
    bus(1'b1, CTRL_OFFSET, 4'h2, 32'h00000000);
    bus(1'b0, CTRL_OFFSET, 4'hF, 32'h0);
    chk("ctrl lanes", 32'h000000FF, q);
    bus(1'b1, CTRL_OFFSET, 4'h3, 32'h0000FFFF);
    bus(1'b0, CTRL_OFFSET, 4'hF, 32'h0);
    chk("ctrl bit14", 32'h0000BFFF, q);
    bus(1'b0, 4'h8, 4'hF, 32'h0);
    chk("unmapped", 32'h00000000, q);
  endtask
  task gate_sweep;
    logic [15:0] w;
    logic e;
    for (int i = 0; i < 22; i++)
    begin
      w = i < 6 ? 16'h0100 << i : i < 12 ? 16'h0040 | (16'h0001 << (i - 6)) :
        i < 18 ? 16'h0080 | (16'h0001 << (i - 12)) : i == 18 ? 16'h0040 : i == 19 ? 16'h0080 :
        i == 20 ? 16'h3000 : 16'h006A;
      w[15] = i[0];
      bus(1'b1, CTRL_OFFSET, 4'h3, {16'h0000, w});
      for (int s = 0; s < 16; s++)
      begin
        lvl <= s[3:0];
        repeat (3) @(posedge ref_clk_i);
        e = exp_or(w, s[0], s[1], s[2]);
        chk("blank", {31'h0, e}, {31'h0, blank_o});
        chk("comp", (e && s[3] == !w[15]) ? {31'h0, w[15]} : {31'h0, s[3]}, {31'h0, comp_o});
      end
    end
  endtask
  // Status word with source A blanking a high level; status writes and upper lanes ignored
  task stat_checks;
    bus(1'b1, CTRL_OFFSET, 4'h3, 32'h00000200);
    lvl <= 4'h9;
    repeat (3) @(posedge ref_clk_i);
    bus(1'b0, STAT_OFFSET, 4'hF, 32'h0);
    chk("status", 32'h00000005, q);
    bus(1'b1, STAT_OFFSET, 4'hF, 32'hFFFFFFFF);
    bus(1'b1, CTRL_OFFSET, 4'hC, 32'hFFFFFFFF);
    bus(1'b0, CTRL_OFFSET, 4'hF, 32'h0);
    chk("ctrl kept", 32'h00000200, q);
  endtask
  // Reset in mid-run: outputs idle while held, control back to its reset value
  task reset_checks;
    rst_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    chk("wait in reset", 32'h00000001, {31'h0, wait_o});
    chk("blank in reset", 32'h00000000, {31'h0, blank_o});
    chk("comp in reset", 32'h00000000, {31'h0, comp_o});
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    bus(1'b0, CTRL_OFFSET, 4'hF, 32'h0);
    chk("ctrl after reset", {16'h0000, CTRL_RESET}, q);
  endtask
  initial
  begin
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    reg_checks();
    stat_checks();
    gate_sweep();
    reset_checks();
    close_out();
  end
endmodule
